// ==== bhm_multiplier.sv ====
// Top of the byte hardware multiplier with its product register pair.
// Assumes the decoder pulses the multiply strobe for one cycle per instruction
// and that status flags arrive from, and return to, the core each cycle.
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - Operands are unsigned; the full 16-bit product is kept.
// - A multiply completes in one cycle; product ready for next instruction.
// - High product byte gets bits 15..8, low byte gets bits 7..0.
// - Multiply leaves carry, digit carry, zero, overflow, negative flags unchanged.
// - One operand from working register, the other from the file register.
module bhm_multiplier
    import bhm_pkg::*;
(
    input  wire logic                     sys_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     multiply_working_by_file_instr,
    input  wire logic [BHM_OPERAND_W-1:0] working_register,
    input  wire logic [BHM_OPERAND_W-1:0] file_operand,
    input  wire logic                     prod_high_wr,
    input  wire logic                     prod_low_wr,
    input  wire logic [BHM_OPERAND_W-1:0] prod_wr_data,
    input  wire logic [BHM_FLAGS_W-1:0]   status_flags_in,
    input  wire logic                     status_flags_wr,
    output logic      [BHM_OPERAND_W-1:0] product_high_byte,
    output logic      [BHM_OPERAND_W-1:0] product_low_byte,
    output logic      [BHM_FLAGS_W-1:0]   status_flags,
    output logic                          mult_done
);
    // The array output at full width, then split into its two bytes.
    logic [BHM_PRODUCT_W-1:0] product_w;
    logic [BHM_OPERAND_W-1:0] product_upper_w;
    logic [BHM_OPERAND_W-1:0] product_lower_w;

    // The product register pair; each byte is a group of its own.
    logic [BHM_OPERAND_W-1:0] prod_high_q;
    logic [BHM_OPERAND_W-1:0] prod_high_d;
    logic [BHM_OPERAND_W-1:0] prod_low_q;
    logic [BHM_OPERAND_W-1:0] prod_low_d;

    // Status flags held on behalf of the core.
    logic [BHM_FLAGS_W-1:0]   flags_q;
    logic [BHM_FLAGS_W-1:0]   flags_d;

    // Completion tracking and its registered marker.
    bhm_state_t               state_q;
    bhm_state_t               state_d;
    logic                     done_q;
    logic                     done_d;

    // Write requests that survive the multiply-cycle refusal.
    logic                     high_wr_ok;
    logic                     low_wr_ok;
    logic                     flags_wr_ok;

    // The array sees its operands directly, so no setup cycle is spent.
    // This puts the whole array in one cycle path, traded for latency.
    bhm_mult_core u_core
    (
        .op_a    (working_register),
        .op_b    (file_operand),
        .product (product_w)
    );

    // Split the array output into the two bytes of the register pair.
    assign product_upper_w = product_w[BHM_PRODUCT_W-1:BHM_OPERAND_W];
    assign product_lower_w = product_w[BHM_OPERAND_W-1:0];

    // A direct write or a flag update in a multiply cycle is refused.
    // The instruction that writes the pair cannot also be a multiply,
    // so a collision means a decoder fault and the multiply wins.
    assign high_wr_ok  = prod_high_wr && !multiply_working_by_file_instr;
    assign low_wr_ok   = prod_low_wr && !multiply_working_by_file_instr;
    assign flags_wr_ok = status_flags_wr && !multiply_working_by_file_instr;

    // High product byte: a multiply loads it, otherwise a write may.
    // With neither it keeps its value for any later reader.
    always_comb
    begin
        prod_high_d = prod_high_q;
        if (multiply_working_by_file_instr)
        begin
            prod_high_d = product_upper_w;
        end
        else if (high_wr_ok)
        begin
            prod_high_d = prod_wr_data;
        end
    end

    // High product byte register.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            prod_high_q <= BHM_PROD_RESET;
        end
        else
        begin
            prod_high_q <= prod_high_d;
        end
    end

    // Low product byte: same priority as the high byte.
    // On a multiply both bytes load on one edge, so a reader never sees a torn product.
    always_comb
    begin
        prod_low_d = prod_low_q;
        if (multiply_working_by_file_instr)
        begin
            prod_low_d = product_lower_w;
        end
        else if (low_wr_ok)
        begin
            prod_low_d = prod_wr_data;
        end
    end

    // Low product byte register.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            prod_low_q <= BHM_PROD_RESET;
        end
        else
        begin
            prod_low_q <= prod_low_d;
        end
    end

    // Flags follow the core's updates except while a multiply executes.
    // The multiply never computes a flag, so holding is all it needs.
    always_comb
    begin
        flags_d = flags_q;
        if (flags_wr_ok)
        begin
            flags_d = status_flags_in;
        end
    end

    // Flag register.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            flags_q <= BHM_FLAGS_RESET;
        end
        else
        begin
            flags_q <= flags_d;
        end
    end

    // Completion state: one cycle in the done state per multiply strobe.
    // Back-to-back multiplies keep it there, one cycle behind each strobe.
    always_comb
    begin
        case (state_q)
            BHM_IDLE:
            begin
                state_d = multiply_working_by_file_instr ? BHM_DONE : BHM_IDLE;
            end
            BHM_DONE:
            begin
                state_d = multiply_working_by_file_instr ? BHM_DONE : BHM_IDLE;
            end
            default:
            begin
                state_d = BHM_IDLE;
            end
        endcase
    end

    // Completion state register.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            state_q <= BHM_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Done marker decoded ahead of the flop, so the output has no gate after it.
    always_comb
    begin
        done_d = (state_d == BHM_DONE);
    end

    // Done marker register.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= done_d;
        end
    end

    // Every output comes straight from a register.
    assign product_high_byte = prod_high_q;
    assign product_low_byte  = prod_low_q;
    assign status_flags      = flags_q;
    assign mult_done         = done_q;
endmodule // bhm_multiplier
`default_nettype wire

// ==== bhm_pkg.sv ====
// Package for the byte hardware multiplier: widths and reset values.
// Assumes a single core clock domain with synchronous active-high reset.
package bhm_pkg;
    localparam int unsigned BHM_OPERAND_W   = 8;
    localparam int unsigned BHM_PRODUCT_W   = 16;
    localparam int unsigned BHM_FLAGS_W     = 5;
    localparam int unsigned BHM_MULT_CYCLES = 1;
    localparam logic [7:0]  BHM_PROD_RESET  = 8'h00;
    localparam logic [4:0]  BHM_FLAGS_RESET = 5'h00;

    // Controller states.
    typedef enum logic [1:0]
    {
        BHM_IDLE = 2'b01,
        BHM_DONE = 2'b10
    } bhm_state_t;
endpackage

// ==== bhm_mult_core.sv ====
// Combinational unsigned 8 by 8 multiplier array.
// Assumes the caller registers the result within the same cycle.
`timescale 1ns/1ps
`default_nettype none
module bhm_mult_core
    import bhm_pkg::*;
(
    input  wire logic [BHM_OPERAND_W-1:0] op_a,
    input  wire logic [BHM_OPERAND_W-1:0] op_b,
    output logic      [BHM_PRODUCT_W-1:0] product
);
    // Shift-and-add array; op_a widened to the product width so no bit is lost.
    always_comb
    begin
        product = '0;
        for (int i = 0; i < BHM_OPERAND_W; i++)
        begin
            if (op_b[i])
            begin
                product = product + (BHM_PRODUCT_W'(op_a) << i);
            end
        end
    end
endmodule // bhm_mult_core
`default_nettype wire

// ==== bhm_unused_note_none.sv ====
// Intentionally empty design unit list: nothing else is required.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== bhm_core_model.sv ====
// Core decoder and working register model.
// Assumes go is one cycle per multiply.
`timescale 1ns/1ps
`default_nettype none
module bhm_core_model (
    input wire logic       sys_clk,
    input wire logic       go,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    output logic           strobe,
    output logic     [7:0] w,
    output logic     [7:0] f
);
    // The file bus toggles between instructions, so stale data is never trusted.
    always_ff @(posedge sys_clk)
    begin
        strobe <= go;
        w <= go ? a : w;
        f <= go ? b : ~f;
    end
endmodule // bhm_core_model
`default_nettype wire

// ==== bhm_multiplier_assertions.sv ====
// Port checker for the multiplier.
// Assumes one clock and a sync reset.
`timescale 1ns/1ps
`default_nettype none
module bhm_mult_chk (
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    input wire logic       multiply_working_by_file_instr,
    input wire logic [7:0] working_register,
    input wire logic [7:0] file_operand,
    input wire logic       prod_high_wr,
    input wire logic       prod_low_wr,
    input wire logic [7:0] prod_wr_data,
    input wire logic [7:0] product_high_byte,
    input wire logic [7:0] product_low_byte,
    input wire logic [4:0] status_flags,
    input wire logic       mult_done
);
    // All checks look one cycle after their cause.
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    wire s = multiply_working_by_file_instr;
    wire [15:0] p = {product_high_byte, product_low_byte};
    a_product_full:
        assert property (s |=> p == 16'($past(working_register)) * $past(file_operand))
        else $error("bad product");
    a_low_byte:
        assert property (s |=> product_low_byte == 8'($past(working_register) *
            $past(file_operand))) else $error("bad low byte");
    a_done_next:
        assert property (mult_done == $past(s)) else $error("bad done");
    a_flags_kept:
        assert property (s |=> $stable(status_flags)) else $error("flags moved");
    a_product_hold:
        assert property (!s && !prod_high_wr && !prod_low_wr |=> $stable(p))
        else $error("product moved");
    a_direct_write:
        assert property (prod_low_wr && !s |=> product_low_byte == $past(prod_wr_data))
        else $error("bad write");
    c_mult: cover property (s ##1 mult_done);
    c_write: cover property (prod_low_wr && !s);
    c_idle: cover property (!s [*3]);
endmodule // bhm_mult_chk
bind bhm_multiplier bhm_mult_chk bhm_mult_chk_inst (.*);
`default_nettype wire

// ==== test_byte_hardware_multiplier.sv ====
// Bench for the multiplier behind the core model.
// Assumes a 200 MHz clock and sync reset.
`timescale 1ns/1ps
`default_nettype none
module test_byte_hardware_multiplier;
    logic       sys_clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       go      = 1'b0;
    logic       hwr     = 1'b0;
    logic       lwr     = 1'b0;
    logic       fwr     = 1'b0;
    logic [7:0] a       = 8'h00;
    logic [7:0] b       = 8'h00;
    logic [7:0] wd      = 8'h00;
    logic [4:0] fin     = 5'h00;
    logic       stb;
    logic       done;
    logic [7:0] w;
    logic [7:0] f;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [4:0] fl;
    int         errors  = 0;
    int         checked = 0;
    int         cyc     = 0;
    always #2.5 sys_clk = ~sys_clk;
    bhm_core_model bhm_core_model_inst (.sys_clk(sys_clk), .go(go), .a(a), .b(b),
        .strobe(stb), .w(w), .f(f));
    bhm_multiplier bhm_multiplier_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .multiply_working_by_file_instr(stb), .working_register(w), .file_operand(f),
        .prod_high_wr(hwr), .prod_low_wr(lwr), .prod_wr_data(wd),
        .status_flags_in(fin), .status_flags_wr(fwr), .product_high_byte(hi),
        .product_low_byte(lo), .status_flags(fl), .mult_done(done));
    task cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task complete_run;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // One multiply through the core model; a flag write rides the strobe cycle
    // when fw is set. The product and done marker stand on return.
    task mul_op(input logic [7:0] x, input logic [7:0] y, input logic fw);
        @(posedge sys_clk) go <= 1'b1;
        a <= x;
        b <= y;
        @(posedge sys_clk) go <= 1'b0;
        fwr <= fw;
        fin <= 5'h0a;
        @(posedge sys_clk) fwr <= 1'b0;
        #1;
    endtask
    // Direct writes of the high then the low product byte.
    task wr_prod(input logic [7:0] h, input logic [7:0] l);
        @(posedge sys_clk) hwr <= 1'b1;
        wd <= h;
        @(posedge sys_clk) hwr <= 1'b0;
        lwr <= 1'b1;
        wd <= l;
        @(posedge sys_clk) lwr <= 1'b0;
        #1;
    endtask
    task test_unsigned;
        mul_op(8'hff, 8'hff, 1'b0);
        cmp({hi, lo}, 16'hfe01);
        cmp({15'h0000, done}, 16'h0001);
        @(posedge sys_clk);
        #1;
        cmp({15'h0000, done}, 16'h0000);
        mul_op(8'h80, 8'h02, 1'b0);
        cmp({hi, lo}, 16'h0100);
        $display("unsigned test done");
    endtask
    task test_flags;
        @(posedge sys_clk) fwr <= 1'b1;
        fin <= 5'h15;
        @(posedge sys_clk) fwr <= 1'b0;
        @(posedge sys_clk);
        #1;
        cmp({11'h000, fl}, 16'h0015);
        mul_op(8'h0f, 8'h11, 1'b1);
        cmp({11'h000, fl}, 16'h0015);
        cmp({hi, lo}, 16'h00ff);
        $display("flags test done");
    endtask
    task test_hold;
        wr_prod(8'h12, 8'h34);
        cmp({hi, lo}, 16'h1234);
        repeat (3) @(posedge sys_clk);
        #1;
        cmp({hi, lo}, 16'h1234);
        $display("hold test done");
    endtask
    // Signed 8 by 8 by sign corrections on the high byte, written back.
    task test_signed8(input logic [7:0] x, input logic [7:0] y);
        logic [15:0] want;
        logic [7:0]  h;
        want = $signed(x) * $signed(y);
        mul_op(x, y, 1'b0);
        h = hi;
        if (y[7]) h = h - x;
        if (x[7]) h = h - y;
        wr_prod(h, lo);
        cmp({hi, lo}, want);
        $display("signed byte test done");
    endtask
    // Sixteen by sixteen from four weighted partial products.
    task test_wide(input logic [15:0] x, input logic [15:0] y, input logic sgn);
        logic [31:0] want;
        logic [31:0] res;
        if (sgn)
            want = $signed(x) * $signed(y);
        else
            want = x * y;
        mul_op(x[15:8], y[15:8], 1'b0);
        res[31:16] = {hi, lo};
        mul_op(x[7:0], y[7:0], 1'b0);
        res[15:0] = {hi, lo};
        mul_op(x[7:0], y[15:8], 1'b0);
        res = res + {8'h00, hi, lo, 8'h00};
        mul_op(x[15:8], y[7:0], 1'b0);
        res = res + {8'h00, hi, lo, 8'h00};
        if (sgn && y[15]) res[31:16] = res[31:16] - x;
        if (sgn && x[15]) res[31:16] = res[31:16] - y;
        cmp(res[31:16], want[31:16]);
        cmp(res[15:0], want[15:0]);
        $display("wide test done");
    endtask
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 400)
        begin
            errors++;
            complete_run;
        end
    end
    initial
    begin
        repeat (6) @(posedge sys_clk);
        sys_rst <= 0;
        test_unsigned;
        test_flags;
        test_hold;
        test_signed8(8'hf6, 8'h07);
        test_signed8(8'h85, 8'hfb);
        test_wide(16'hbeef, 16'h1234, 1'b0);
        test_wide(16'hfedc, 16'h8765, 1'b1);
        complete_run;
    end
endmodule // test_byte_hardware_multiplier
`default_nettype wire
